// ==== hdl/ccd_params.svh ====
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
// register indexes; byte address is four times the index
`define CCD_IDX_CONFIG      8'h06
`define CCD_IDX_THR_UPPER   8'h07
`define CCD_IDX_THR_LOWER   8'h08
// configuration field positions
`define CCD_DLY_HI          12
`define CCD_DLY_LO          9
`define CCD_CHOP_EN_BIT     8
`define CCD_ALLCH_BIT       7
`define CCD_NUM_HI          6
`define CCD_NUM_LO          4
`define CCD_LEN_HI          3
`define CCD_LEN_LO          1
`define CCD_DET_EN_BIT      0
// reset values
`define CCD_CONFIG_RST      16'h0600
`define CCD_THR_UPPER_RST   16'h0000
`define CCD_THR_LOWER_RST   16'h0000
// writable masks
`define CCD_CONFIG_WMASK    16'h1fff
`define CCD_THR_LOWER_WMASK 16'hff0f
`endif

// ==== hdl/ccd_pkg.sv ====
package ccd_pkg;
  // avalon request bundle
  typedef struct packed {
    logic        read;       // read strobe
    logic        write;      // write strobe
    logic [7:0]  address;    // word address
    logic [31:0] writedata;  // write data
    logic [3:0]  byteenable; // byte lanes
  } ccd_req_t;
  // bus slave states
  typedef enum logic [0:0] {CCD_IDLE, CCD_DONE} ccd_state_t;
endpackage

// ==== hdl/ccd_config.sv ====
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_params.svh"

module ccd_config #(
  parameter int CHANNELS = 6  // converter channel count
) (
  input  wire logic                       clock_in,     // 40 MHz clock
  input  wire logic                       nrst_in,      // sync reset, low
  input  wire logic [7:0]                 address_in,   // word address
  input  wire logic                       read_in,      // avalon read
  input  wire logic                       write_in,     // avalon write
  input  wire logic [31:0]                writedata_in, // avalon wdata
  input  wire logic [3:0]                 byteenable_in,// byte lanes
  input  wire logic [CHANNELS*24-1:0]     result_in,    // channel results
  output logic [31:0]                     readdata_out, // avalon rdata
  output logic                            waitrequest_out, // stall
  output logic                            response_err_out, // unmapped
  output logic [3:0]                      chop_delay_select_out, // code
  output logic [16:0]                     chop_delay_cycles_out, // clocks
  output logic                            chop_enable_out, // chopping
  output logic                            detect_all_channels_out, // all
  output logic [7:0]                      detect_exceed_count_out, // count
  output logic [11:0]                     detect_measure_length_out, // len
  output logic                            detect_mode_enable_out, // on
  output logic [23:0]                     detect_threshold_out, // signed
  output logic [3:0]                      dc_removal_setting_out, // filter
  output logic [CHANNELS-1:0]             channel_exceed_out, // per chan
  output logic                            detect_qualified_out // any/all
);

  // register map, word indexes on address_in:
  //   06h chop and detect configuration
  //   07h detect threshold, bits 23:8
  //   08h threshold bits 7:0 and dc removal code
  // anything else completes with response_err_out set
  // only the low 16 bits of a bus word are used
  // byte lane 0 covers bits 7:0, lane 1 bits 15:8
  // lanes 2 and 3 and write data 31:16 are ignored
  // the upper half of read data is always zero

  ccd_pkg::ccd_req_t   req;           // bundled request
  ccd_pkg::ccd_state_t state_reg;     // slave state
  logic [15:0]         config_reg;    // chop and detect config
  logic [15:0]         thr_upper_reg; // threshold bits 23:8
  logic [15:0]         thr_lower_reg; // threshold 7:0 and filter
  logic [15:0]         wmask;         // byte-lane mask, low half
  logic [CHANNELS-1:0] exceed;        // per-channel compare
  logic [23:0]         threshold;     // assembled threshold

  // bundle the bus inputs so the processes read one
  // request; wmask widens the two used byte enables
  assign req = '{read_in, write_in, address_in, writedata_in, byteenable_in};
  assign wmask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

  // a partly enabled write keeps the lanes it skips
  // bits outside the writable mask never change, so
  // reserved config bits and lower bits 7:4 stay zero
  // merge a write into a register under lane and writable masks
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] lanes,
                                        input logic [15:0] wmsk);
    logic [15:0] m;
    m = lanes & wmsk;
    merge = (old & ~m) | (wd & m);
  endfunction

  // code 0 gives 2 clocks, code 15 gives 65536,
  // hence the 17-bit result
  // shift cannot overflow: 2 << 15 fits 17 bits
  // delay in modulator clocks: 2 shifted left by the code
  function automatic logic [16:0] chop_cycles(input logic [3:0] code);
    chop_cycles = 17'h0_0002 << code;
  endfunction

  // lengths are not powers of two above 512,
  // so a table rather than a shift
  // default branch covers code 7
  // measurement length in conversion periods
  function automatic logic [11:0] meas_len(input logic [2:0] code);
    case (code)
      3'h0:    meas_len = 12'h080; // 128
      3'h1:    meas_len = 12'h100; // 256
      3'h2:    meas_len = 12'h200; // 512
      3'h3:    meas_len = 12'h300; // 768
      3'h4:    meas_len = 12'h500; // 1280
      3'h5:    meas_len = 12'h700; // 1792
      3'h6:    meas_len = 12'ha00; // 2560
      default: meas_len = 12'he00; // 3584
    endcase
  endfunction

  // compares a full word index, no aliasing of
  // the three registers across the address space
  // used by the write and the read decode alike
  // decode hit for a word index
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  // bus handshake timing, edge by edge:
  //   edge 0: read or write seen while idle; the
  //           write is stored and read data loaded
  //   edge 1: waitrequest_out is low, master takes
  //           the answer and drops its strobe
  //   edge 2: waitrequest_out is high again
  // a strobe still high at edge 1 is not taken
  // again because the slave is then in done
  // a new request may be raised right after edge 1
  // waitrequest_out idles high, also in reset
  // a request during reset is ignored; raise the
  // first one once nrst_in is high
  // one wait cycle per access: idle takes, done releases
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_reg <= ccd_pkg::CCD_IDLE;
    end else begin
      case (state_reg)
        ccd_pkg::CCD_IDLE: begin
          if (req.read || req.write) begin
            state_reg <= ccd_pkg::CCD_DONE;
          end
        end
        default: begin
          state_reg <= ccd_pkg::CCD_IDLE;
        end
      endcase
    end
  end

  // waitrequest high except in the completing cycle
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= !(state_reg == ccd_pkg::CCD_IDLE
                           && (req.read || req.write));
    end
  end

  // writes commit at the taking edge, the same edge
  // at which waitrequest_out drops; the master holds
  // its request until then, so nothing is lost
  // bits 15:13 are not writable and read zero
  // partly enabled writes merge lane by lane
  // configuration register writes
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      config_reg <= `CCD_CONFIG_RST;
    end else if (state_reg == ccd_pkg::CCD_IDLE && req.write
                 && hit(req.address, `CCD_IDX_CONFIG)) begin
      config_reg <= merge(config_reg, req.writedata[15:0], wmask,
                          `CCD_CONFIG_WMASK);
    end
  end

  // the threshold spans two registers written by
  // separate accesses; between them the compare
  // sees a mix of old and new halves, so software
  // should clear detect mode while it updates both
  // reset to zero: threshold 0, any positive result exceeds
  // threshold upper register at 07h
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      thr_upper_reg <= `CCD_THR_UPPER_RST;
    end else if (state_reg == ccd_pkg::CCD_IDLE && req.write
                 && hit(req.address, `CCD_IDX_THR_UPPER)) begin
      thr_upper_reg <= merge(thr_upper_reg, req.writedata[15:0], wmask,
                             16'hffff);
    end
  end

  // bits 15:8 threshold low byte, 7:4 reserved,
  // 3:0 dc removal code passed through as is
  // the reserved nibble is masked on write and
  // forced to zero on read
  // threshold lower register at 08h; bits 7:4 never stored
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      thr_lower_reg <= `CCD_THR_LOWER_RST;
    end else if (state_reg == ccd_pkg::CCD_IDLE && req.write
                 && hit(req.address, `CCD_IDX_THR_LOWER)) begin
      thr_lower_reg <= merge(thr_lower_reg, req.writedata[15:0], wmask,
                             `CCD_THR_LOWER_WMASK);
    end
  end

  // read data is loaded at the taking edge and then
  // holds until the next completion; a write also
  // loads it, with the addressed register's old value
  // unmapped accesses read zero and set the flag;
  // an unmapped write changes nothing
  // read data is valid in the cycle waitrequest_out is low
  // read data and unmapped flag, valid when waitrequest drops
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      readdata_out     <= 32'h0000_0000;
      response_err_out <= 1'b0;
    end else if (state_reg == ccd_pkg::CCD_IDLE
                 && (req.read || req.write)) begin
      response_err_out <= 1'b0;
      readdata_out     <= 32'h0000_0000;
      if (hit(req.address, `CCD_IDX_CONFIG)) begin
        readdata_out <= {16'h0000, config_reg};
      end else if (hit(req.address, `CCD_IDX_THR_UPPER)) begin
        readdata_out <= {16'h0000, thr_upper_reg};
      end else if (hit(req.address, `CCD_IDX_THR_LOWER)) begin
        readdata_out <= {16'h0000, thr_lower_reg[15:8], 4'h0,
                         thr_lower_reg[3:0]};
      end else begin
        response_err_out <= 1'b1; // unmapped: reads zero
      end
    end
  end

  // every output toward the converter core is a
  // flip-flop, one edge behind its register; a
  // write therefore reaches these ports one edge
  // after the taking edge
  // reset values match the configuration reset:
  //   delay code 3 (16 clocks), count 1, length 128
  // the delay is also given in clocks so the core
  // need not decode the code again
  // field decode toward the converter core
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      chop_delay_select_out     <= 4'h3;
      chop_delay_cycles_out     <= 17'h0_0010;
      chop_enable_out           <= 1'b0;
      detect_all_channels_out   <= 1'b0;
      detect_exceed_count_out   <= 8'h01;
      detect_measure_length_out <= 12'h080;
      detect_mode_enable_out    <= 1'b0;
      detect_threshold_out      <= 24'h00_0000;
      dc_removal_setting_out    <= 4'h0;
    end else begin
      chop_delay_select_out   <= config_reg[`CCD_DLY_HI:`CCD_DLY_LO];
      chop_delay_cycles_out   <=
        chop_cycles(config_reg[`CCD_DLY_HI:`CCD_DLY_LO]);
      chop_enable_out         <= config_reg[`CCD_CHOP_EN_BIT];
      detect_all_channels_out <= config_reg[`CCD_ALLCH_BIT];
      detect_exceed_count_out <=
        8'h01 << config_reg[`CCD_NUM_HI:`CCD_NUM_LO];
      detect_measure_length_out <=
        meas_len(config_reg[`CCD_LEN_HI:`CCD_LEN_LO]);
      detect_mode_enable_out  <= config_reg[`CCD_DET_EN_BIT];
      detect_threshold_out    <= threshold;
      dc_removal_setting_out  <= thr_lower_reg[3:0];
    end
  end

  // upper register is the signed high part,
  // lower byte appended below it
  // assemble signed threshold from both parts
  assign threshold = {thr_upper_reg, thr_lower_reg[15:8]};

  // strict greater-than: a result equal to the
  // threshold does not count as exceeded
  // both sides are 24-bit two's complement
  // results arrive as level inputs, one per 24-bit slice
  // signed compare of each channel result against threshold
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      exceed[i] = $signed(result_in[i*24 +: 24])
                  > $signed(threshold);
    end
  end

  // qualification only; counting exceedances over
  // the measurement length is left to the core,
  // which gets the decoded count and length
  // detect mode off forces the qualified flag low
  // any: one channel suffices; all: every channel
  // flags are one edge behind result_in
  // per-channel flags and any/all qualification
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      channel_exceed_out   <= '0;
      detect_qualified_out <= 1'b0;
    end else begin
      channel_exceed_out   <= exceed;
      detect_qualified_out <= config_reg[`CCD_DET_EN_BIT]
        && (config_reg[`CCD_ALLCH_BIT] ? &exceed : |exceed);
    end
  end

  // not covered here: per-channel settings, the
  // detection counters and the dc removal filter
  // itself; this block only holds and decodes

endmodule
`default_nettype wire

// ==== test/ccd_config_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccd_chk #(
  parameter int CHANNELS = 6  // channel count
) (
  input wire logic                   clock_in,         // clock
  input wire logic                   nrst_in,          // reset, low
  input wire logic [7:0]             address_in,       // word index
  input wire logic                   read_in,          // read strobe
  input wire logic                   write_in,         // write strobe
  input wire logic [31:0]            writedata_in,     // write data
  input wire logic [CHANNELS*24-1:0] result_in,        // results
  input wire logic [31:0]            readdata_out,     // read data
  input wire logic                   waitrequest_out,  // stall
  input wire logic                   response_err_out, // unmapped
  input wire logic [3:0]             chop_delay_select_out, // code
  input wire logic [16:0]            chop_delay_cycles_out, // wait
  input wire logic [23:0]            detect_threshold_out,  // threshold
  input wire logic [3:0]             dc_removal_setting_out, // filter
  input wire logic [CHANNELS-1:0]    channel_exceed_out      // flags
);
  // one clock domain, one reset
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // a taken request completes on the very next cycle
  property p_take;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_take: assert property (p_take) else $error("late completion");
  // completion lasts exactly one cycle
  property p_one;
    !waitrequest_out |=> waitrequest_out;
  endproperty
  a_one: assert property (p_one) else $error("long completion");
  // delay in clocks doubles from two
  property p_dly;
    chop_delay_cycles_out == (17'h2 << chop_delay_select_out);
  endproperty
  a_dly: assert property (p_dly) else $error("bad chop delay");
  // upper write lands in threshold bits 23:8
  property p_up;
    write_in && waitrequest_out && address_in == 8'h07 |=> ##1
      detect_threshold_out[23:8] == $past(writedata_in[15:0], 2);
  endproperty
  a_up: assert property (p_up) else $error("upper not applied");
  // lower write lands in bits 7:0 and the filter code
  property p_lo;
    write_in && waitrequest_out && address_in == 8'h08 |=> ##1
      {detect_threshold_out[7:0], dc_removal_setting_out} ==
      {$past(writedata_in[15:8], 2), $past(writedata_in[3:0], 2)};
  endproperty
  a_lo: assert property (p_lo) else $error("lower not applied");
  // reserved lower bits read zero
  property p_rsv;
    read_in && !waitrequest_out && address_in == 8'h08 |->
      readdata_out[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved not zero");
  // unmapped completion flags an error
  property p_err;
    !waitrequest_out && !(address_in inside {8'h06, 8'h07, 8'h08}) |->
      response_err_out;
  endproperty
  a_err: assert property (p_err) else $error("no error flag");
  // channel zero compares signed, one cycle late
  property p_exc;
    $past(nrst_in) |-> channel_exceed_out[0] ==
      ($signed($past(result_in[23:0])) >
       $signed(detect_threshold_out));
  endproperty
  a_exc: assert property (p_exc) else $error("bad exceed flag");
endmodule
bind ccd_config ccd_chk #(.CHANNELS(CHANNELS)) chk_u (
  .clock_in(clock_in), .nrst_in(nrst_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .result_in(result_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .response_err_out(response_err_out),
  .chop_delay_select_out(chop_delay_select_out),
  .chop_delay_cycles_out(chop_delay_cycles_out),
  .detect_threshold_out(detect_threshold_out),
  .dc_removal_setting_out(dc_removal_setting_out),
  .channel_exceed_out(channel_exceed_out));
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module tb;
  logic clock_in = 1'b0, nrst_in, read_in, write_in, wq, qd; // drive
  logic [7:0] address_in; // word index
  logic [31:0] writedata_in, readdata_out, q; // data
  logic [3:0] byteenable_in, dsel, dcs; // lanes, codes
  logic [143:0] result_in; // six results
  logic [16:0] dcy; // delay clocks
  logic [7:0] cnt; // exceed count
  logic [11:0] len; // length
  logic [23:0] thr; // threshold
  logic [5:0] exc; // exceed flags
  logic [15:0] wd; // config word
  logic ch, all, en, qual; // config bits, qualified flag
  int n_tests = 0, err_total = 0, cyc = 0; // counters
  logic [11:0] lens [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
                            12'h500, 12'h700, 12'ha00, 12'he00};
  ccd_config dut_u (.clock_in(clock_in), .nrst_in(nrst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .result_in(result_in), .readdata_out(readdata_out),
    .waitrequest_out(wq), .response_err_out(qd),
    .chop_delay_select_out(dsel), .chop_delay_cycles_out(dcy),
    .chop_enable_out(ch), .detect_all_channels_out(all),
    .detect_exceed_count_out(cnt), .detect_measure_length_out(len),
    .detect_mode_enable_out(en), .detect_threshold_out(thr),
    .dc_removal_setting_out(dcs), .channel_exceed_out(exc),
    .detect_qualified_out(qual));
  // clock and hang guard
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clock_in);
    read_in <= !w;
    write_in <= w;
    address_in <= a;
    writedata_in <= {16'h0000, d};
    // no cycle limit here: only the bench timeout ends a wait
    do begin
      @(posedge clock_in);
    end while (wq !== 1'b0);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  // read and compare
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(q, {16'h0000, e})
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {nrst_in, read_in, write_in, address_in, writedata_in} = '0;
    byteenable_in = 4'hf;
    result_in = '0;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h06, 16'h0600);
    rd(8'h07, 16'h0000);
    rd(8'h08, 16'h0000);
    `CHK({dsel, dcy}, {4'h3, 17'h0_0010})
    `CHK({cnt, len}, {8'h01, 12'h080})
    `CHK({thr, dcs}, {24'h00_0000, 4'h0})
    // every code of every config field, reserved bits set
    for (int i = 0; i < 16; i++) begin
      wd = {3'h7, i[3:0], i[0], ~i[0], i[2:0], i[2:0], i[1]};
      acc(1'b1, 8'h06, wd);
      rd(8'h06, wd & 16'h1fff);
      `CHK(dsel, i[3:0])
      `CHK(dcy, 17'h2 << i)
      `CHK({ch, all, en}, {i[0], ~i[0], i[1]})
      `CHK(cnt, 8'h01 << i[2:0])
      `CHK(len, lens[i[2:0]])
    end
    acc(1'b1, 8'h07, 16'h8001);
    acc(1'b1, 8'h08, 16'ha5ff);
    rd(8'h08, 16'ha50f);
    rd(8'h07, 16'h8001);
    `CHK({thr, dcs}, {24'h8001a5, 4'hf})
    // channel one equals threshold, only channel zero exceeds
    acc(1'b1, 8'h07, 16'h0001);
    acc(1'b1, 8'h08, 16'h0000);
    result_in <= {{4{24'hffffff}}, 24'h000100, 24'h000101};
    acc(1'b1, 8'h06, 16'h0001);
    repeat (3) @(posedge clock_in);
    `CHK(exc, 6'h01)
    `CHK(qual, 1'b1)
    acc(1'b1, 8'h06, 16'h0081);
    repeat (3) @(posedge clock_in);
    `CHK(qual, 1'b0)
    rd(8'h09, 16'h0000);
    `CHK(qd, 1'b1)
    acc(1'b1, 8'h05, 16'hffff);
    rd(8'h06, 16'h0081);
    final_report();
  end
endmodule
`default_nettype wire
